// ### core/alu_cfg.svh
// Offsets, field positions, reset values and codes for the ALU block
`ifndef ALU_CFG_SVH
`define ALU_CFG_SVH
`define ADDR_W 8
`define REG_CMD 8'h00
`define REG_WREG 8'h04
`define REG_MEM 8'h08
`define REG_FLAGS 8'h0C
`define REG_TBLPTR 8'h10
`define REG_TBLHI 8'h14
`define REG_PAGE 8'h18
`define REG_PADDR 8'h1C
`define REG_PDATA 8'h20
`define REG_STATUS 8'h24
`define CMD_OP_MSB 4
`define CMD_OP_LSB 0
`define CMD_BIT_MSB 10
`define CMD_BIT_LSB 8
`define CMD_IMM_MSB 23
`define CMD_IMM_LSB 16
`define FLG_BORROW 0
`define FLG_NIBBLE 1
`define FLG_NULL 2
`define FLG_WRAP 3
`define ST_SKIP 0
`define ST_BUSY 1
`define PAGE_W 2
`define PTR_W 8
`define PROG_AW 10
`define PROG_DW 14
`define LAST_PAGE 2'h3
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hFF
`define WORD_ZERO 32'h0000_0000
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ### core/alu_exec.sv
// Rotate, subtract, skip, set, swap, table and XOR execution unit
// Notes on behaviour
// RQ1: Left rotate through flag, bit 7 out.
// RQ2: Plain right rotate wraps bit 0, no flags.
// RQ3: Register-target rotates leave memory untouched.
// RQ4: Right rotate through flag, bit 0 out.
// RQ5: Subtract with borrow, all four flags.
// RQ6: Plain subtract, flag set when not negative.
// RQ7: Immediate subtract into register, same flags.
// RQ8: Memory-target subtracts write the memory byte.
// RQ9: Decrement memory, skip on zero, no flags.
// RQ10: Register decrement form skips on register zero.
// RQ11: Increment with skip on zero, both forms.
// RQ12: Taken skip adds one dummy cycle.
// RQ13: Set byte writes all ones.
// RQ14: Set bit forces one selected bit.
// RQ15: Bit tests skip on one or zero.
// RQ16: Byte test skips on zero byte.
// RQ17: Copy to register, skip on zero.
// RQ18: Nibble swap in place or to register.
// RQ19: Current-page table read, low and high bytes.
// RQ20: Final-page table read, same transfer.
// RQ21: XOR forms update only the null flag.
// RQ22: Null flag on zero; nibble flag on borrow.
// RQ23: Signed wrap flag on signed overflow.
//
// The register offsets and register access over AXI4-Lite are this design's own decisions.
`include "alu_cfg.svh"
module alu_exec (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [`ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // Write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // Read address and data
    input wire logic [`ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready
);
    // Subtract a - b - ~cin; returns {borrow_out, nibble, wrap, diff}
    function automatic logic [10:0] sub_calc(input logic [7:0] a,
                                             input logic [7:0] b,
                                             input logic cin);
        logic [8:0] full;
        logic [4:0] low;
        logic wrap;
        full = {1'b0, a} - {1'b0, b} - {8'h00, ~cin};
        low = {1'b0, a[3:0]} - {1'b0, b[3:0]} - {4'h0, ~cin};
        wrap = (a[7] != b[7]) && (full[7] != a[7]);
        return {~full[8], low[4], wrap, full[7:0]};
    endfunction

    // Zero test of a byte
    function automatic logic is_null(input logic [7:0] v);
        return v == `BYTE_ZERO;
    endfunction

    // Bus side wires
    logic wr_req, wr_ack, wr_err, rd_err;
    logic [`ADDR_W-1:0] wr_addr, rd_addr;
    logic [31:0] wr_data, rd_data;
    logic [3:0] wr_strb;

    // Architectural state
    logic [7:0] wreg_r, mem_r, tblptr_r, tblhi_r;
    logic borrow_r, nibble_r, null_r, wrap_r;
    logic [`PAGE_W-1:0] page_r;
    logic [`PROG_AW-1:0] paddr_r;
    logic skip_r, done_r;
    alu_pkg::seq_e seq_r;
    alu_pkg::op_e op_r;
    logic [2:0] bitsel_r;
    logic [7:0] imm_r;

    // Execution results
    logic [7:0] res, bitmask;
    logic [10:0] sub_out;
    logic to_wreg, to_mem, take_skip, upd_arith, upd_null, upd_borrow;
    logic borrow_nxt, is_table;
    logic [`PROG_AW-1:0] raddr;
    logic [`PROG_DW-1:0] rword;

    // Register decode
    logic hit_cmd, hit_wreg, hit_mem, hit_flags, hit_ptr, hit_page;
    logic hit_paddr, hit_pdata, wr_known, wr_lo;

    axil_slave u_bus (
        .aclk(aclk),
        .aresetn(aresetn),
        .s_awaddr(s_awaddr),
        .s_awvalid(s_awvalid),
        .s_awready(s_awready),
        .s_wdata(s_wdata),
        .s_wstrb(s_wstrb),
        .s_wvalid(s_wvalid),
        .s_wready(s_wready),
        .s_bresp(s_bresp),
        .s_bvalid(s_bvalid),
        .s_bready(s_bready),
        .s_araddr(s_araddr),
        .s_arvalid(s_arvalid),
        .s_arready(s_arready),
        .s_rdata(s_rdata),
        .s_rresp(s_rresp),
        .s_rvalid(s_rvalid),
        .s_rready(s_rready),
        .wr_req(wr_req),
        .wr_addr(wr_addr),
        .wr_data(wr_data),
        .wr_strb(wr_strb),
        .wr_ack(wr_ack),
        .wr_err(wr_err),
        .rd_addr(rd_addr),
        .rd_data(rd_data),
        .rd_err(rd_err)
    );

    prog_mem u_prog (
        .aclk(aclk),
        .we(wr_req && hit_pdata && wr_strb[0] && wr_strb[1]),
        .waddr(paddr_r),
        .wdata(wr_data[`PROG_DW-1:0]),
        .raddr(raddr),
        .rdata(rword)
    );

    // Write address decode; a command is acked when it finishes, or a cycle after the request if byte 0 is not strobed
    assign hit_cmd = wr_addr == `REG_CMD;
    assign hit_wreg = wr_addr == `REG_WREG;
    assign hit_mem = wr_addr == `REG_MEM;
    assign hit_flags = wr_addr == `REG_FLAGS;
    assign hit_ptr = wr_addr == `REG_TBLPTR;
    assign hit_page = wr_addr == `REG_PAGE;
    assign hit_paddr = wr_addr == `REG_PADDR;
    assign hit_pdata = wr_addr == `REG_PDATA;
    assign wr_known = hit_cmd | hit_wreg | hit_mem | hit_flags | hit_ptr |
                      hit_page | hit_paddr | hit_pdata;
    assign wr_lo = wr_req && wr_strb[0];
    assign wr_err = !wr_known;
    assign wr_ack = (wr_req && !hit_cmd) || done_r;

    // Table word address: current page or final page
    assign is_table = (op_r == alu_pkg::op_table_read_current_page) ||
                      (op_r == alu_pkg::op_table_read_final_page);
    assign raddr = (op_r == alu_pkg::op_table_read_final_page) ?
                   {`LAST_PAGE, tblptr_r} : {page_r, tblptr_r}; // RQ19 RQ20

    assign bitmask = 8'h01 << bitsel_r;

    // Operation decode and datapath
    always_comb begin
        res = mem_r;
        to_wreg = 1'b0;
        to_mem = 1'b0;
        take_skip = 1'b0;
        upd_arith = 1'b0;
        upd_null = 1'b0;
        upd_borrow = 1'b0;
        borrow_nxt = borrow_r;
        sub_out = sub_calc(wreg_r, mem_r, 1'b1);
        unique case (op_r)
            alu_pkg::op_rotate_left_thru_flag,
            alu_pkg::op_rotate_left_thru_flag_to_wreg: begin
                res = {mem_r[6:0], borrow_r}; // RQ1
                borrow_nxt = mem_r[7]; // RQ1
                upd_borrow = 1'b1;
                to_wreg = op_r ==
                          alu_pkg::op_rotate_left_thru_flag_to_wreg; // RQ3
                to_mem = !to_wreg;
            end
            alu_pkg::op_rotate_right_plain,
            alu_pkg::op_rotate_right_to_wreg: begin
                res = {mem_r[0], mem_r[7:1]}; // RQ2
                to_wreg = op_r == alu_pkg::op_rotate_right_to_wreg; // RQ3
                to_mem = !to_wreg;
            end
            alu_pkg::op_rotate_right_thru_flag,
            alu_pkg::op_rotate_right_thru_flag_to_wreg: begin
                res = {borrow_r, mem_r[7:1]}; // RQ4
                borrow_nxt = mem_r[0]; // RQ4
                upd_borrow = 1'b1;
                to_wreg = op_r ==
                          alu_pkg::op_rotate_right_thru_flag_to_wreg; // RQ3
                to_mem = !to_wreg;
            end
            alu_pkg::op_subtract_with_borrow,
            alu_pkg::op_subtract_with_borrow_to_mem: begin
                sub_out = sub_calc(wreg_r, mem_r, borrow_r); // RQ5
                res = sub_out[7:0];
                upd_arith = 1'b1;
                to_mem = op_r ==
                         alu_pkg::op_subtract_with_borrow_to_mem; // RQ8
                to_wreg = !to_mem;
            end
            alu_pkg::op_subtract_plain,
            alu_pkg::op_subtract_plain_to_mem: begin
                sub_out = sub_calc(wreg_r, mem_r, 1'b1); // RQ6
                res = sub_out[7:0];
                upd_arith = 1'b1;
                to_mem = op_r == alu_pkg::op_subtract_plain_to_mem; // RQ8
                to_wreg = !to_mem;
            end
            alu_pkg::op_subtract_immediate: begin
                sub_out = sub_calc(wreg_r, imm_r, 1'b1); // RQ7
                res = sub_out[7:0];
                upd_arith = 1'b1;
                to_wreg = 1'b1;
            end
            alu_pkg::op_decrement_skip_if_zero,
            alu_pkg::op_decrement_skip_to_wreg: begin
                res = mem_r - 8'h01; // RQ9
                take_skip = is_null(res); // RQ9 RQ10
                to_wreg = op_r == alu_pkg::op_decrement_skip_to_wreg; // RQ10
                to_mem = !to_wreg;
            end
            alu_pkg::op_increment_skip_if_zero,
            alu_pkg::op_increment_skip_to_wreg: begin
                res = mem_r + 8'h01; // RQ11
                take_skip = is_null(res); // RQ11
                to_wreg = op_r == alu_pkg::op_increment_skip_to_wreg;
                to_mem = !to_wreg;
            end
            alu_pkg::op_set_byte: begin
                res = `BYTE_ONES; // RQ13
                to_mem = 1'b1;
            end
            alu_pkg::op_set_bit: begin
                res = mem_r | bitmask; // RQ14
                to_mem = 1'b1;
            end
            alu_pkg::op_skip_if_bit_one: begin
                take_skip = (mem_r & bitmask) != `BYTE_ZERO; // RQ15
            end
            alu_pkg::op_skip_if_bit_zero: begin
                take_skip = (mem_r & bitmask) == `BYTE_ZERO; // RQ15
            end
            alu_pkg::op_skip_if_null: take_skip = is_null(mem_r); // RQ16
            alu_pkg::op_copy_and_skip_if_null: begin
                res = mem_r; // RQ17
                to_wreg = 1'b1;
                take_skip = is_null(mem_r); // RQ17
            end
            alu_pkg::op_nibble_exchange,
            alu_pkg::op_nibble_exchange_to_wreg: begin
                res = {mem_r[3:0], mem_r[7:4]}; // RQ18
                to_wreg = op_r == alu_pkg::op_nibble_exchange_to_wreg;
                to_mem = !to_wreg;
            end
            alu_pkg::op_table_read_current_page,
            alu_pkg::op_table_read_final_page: begin
                res = rword[7:0];
                to_mem = 1'b1;
            end
            alu_pkg::op_exclusive_or,
            alu_pkg::op_exclusive_or_to_mem: begin
                res = wreg_r ^ mem_r; // RQ21
                upd_null = 1'b1;
                to_mem = op_r == alu_pkg::op_exclusive_or_to_mem;
                to_wreg = !to_mem;
            end
            alu_pkg::op_exclusive_or_immediate: begin
                res = wreg_r ^ imm_r; // RQ21
                upd_null = 1'b1;
                to_wreg = 1'b1;
            end
            default: res = mem_r;
        endcase
    end

    // Sequencer: execute, then a dummy cycle for skips and table fetch
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_r <= alu_pkg::st_idle;
            done_r <= 1'b0;
            skip_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            unique case (seq_r)
                alu_pkg::st_idle: begin
                    if (wr_lo && hit_cmd) begin
                        seq_r <= alu_pkg::st_exec;
                    end
                end
                alu_pkg::st_exec: begin
                    skip_r <= take_skip;
                    if (take_skip || is_table) begin
                        seq_r <= alu_pkg::st_dummy; // RQ12
                    end else begin
                        seq_r <= alu_pkg::st_idle;
                        done_r <= 1'b1;
                    end
                end
                alu_pkg::st_dummy: begin
                    seq_r <= alu_pkg::st_idle;
                    done_r <= 1'b1;
                end
            endcase
            if (wr_req && hit_cmd && !wr_strb[0]) begin
                done_r <= 1'b1;
            end
        end
    end

    // Command capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            op_r <= alu_pkg::op_nop;
            bitsel_r <= 3'h0;
            imm_r <= `BYTE_ZERO;
        end else if (wr_lo && hit_cmd && seq_r == alu_pkg::st_idle) begin
            op_r <= alu_pkg::op_e'(wr_data[`CMD_OP_MSB:`CMD_OP_LSB]);
            bitsel_r <= wr_strb[1] ? wr_data[`CMD_BIT_MSB:`CMD_BIT_LSB] : 3'h0;
            imm_r <= wr_strb[2] ? wr_data[`CMD_IMM_MSB:`CMD_IMM_LSB] :
                     `BYTE_ZERO;
        end
    end

    // Working register
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wreg_r <= `BYTE_ZERO;
        end else if (seq_r == alu_pkg::st_exec && to_wreg) begin
            wreg_r <= res;
        end else if (wr_lo && hit_wreg) begin
            wreg_r <= wr_data[7:0];
        end
    end

    // Addressed memory byte; table low byte lands in the dummy cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            mem_r <= `BYTE_ZERO;
        end else if (seq_r == alu_pkg::st_exec && to_mem && !is_table) begin
            mem_r <= res;
        end else if (seq_r == alu_pkg::st_dummy && is_table) begin
            mem_r <= rword[7:0]; // RQ19 RQ20
        end else if (wr_lo && hit_mem) begin
            mem_r <= wr_data[7:0];
        end
    end

    // Status flags
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            borrow_r <= 1'b0;
            nibble_r <= 1'b0;
            null_r <= 1'b0;
            wrap_r <= 1'b0;
        end else if (seq_r == alu_pkg::st_exec) begin
            if (upd_arith) begin
                borrow_r <= sub_out[10]; // RQ5 RQ6
                nibble_r <= sub_out[9]; // RQ22
                wrap_r <= sub_out[8]; // RQ23
                null_r <= is_null(res); // RQ22
            end else if (upd_borrow) begin
                borrow_r <= borrow_nxt;
            end else if (upd_null) begin
                null_r <= is_null(res); // RQ21 RQ22
            end
        end else if (wr_lo && hit_flags) begin
            borrow_r <= wr_data[`FLG_BORROW];
            nibble_r <= wr_data[`FLG_NIBBLE];
            null_r <= wr_data[`FLG_NULL];
            wrap_r <= wr_data[`FLG_WRAP];
        end
    end

    // Table pointer, high byte, page and program address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tblptr_r <= `BYTE_ZERO;
            tblhi_r <= `BYTE_ZERO;
            page_r <= '0;
            paddr_r <= '0;
        end else begin
            if (wr_lo && hit_ptr) begin
                tblptr_r <= wr_data[7:0];
            end
            if (seq_r == alu_pkg::st_dummy && is_table) begin
                tblhi_r <= {2'h0, rword[`PROG_DW-1:8]}; // RQ19 RQ20
            end
            if (wr_lo && hit_page) begin
                page_r <= wr_data[`PAGE_W-1:0];
            end
            if (wr_lo && hit_paddr && wr_strb[1]) begin
                paddr_r <= wr_data[`PROG_AW-1:0];
            end else if (wr_req && hit_pdata && wr_strb[0] && wr_strb[1]) begin
                paddr_r <= paddr_r + 10'h001;
            end
        end
    end

    // Read mux
    always_comb begin
        rd_data = `WORD_ZERO;
        rd_err = 1'b0;
        unique case (rd_addr)
            `REG_CMD: rd_data = {8'h00, imm_r, 5'h00, bitsel_r, 3'h0, op_r};
            `REG_WREG: rd_data = {24'h0, wreg_r};
            `REG_MEM: rd_data = {24'h0, mem_r};
            `REG_FLAGS: rd_data = {28'h0, wrap_r, null_r, nibble_r, borrow_r};
            `REG_TBLPTR: rd_data = {24'h0, tblptr_r};
            `REG_TBLHI: rd_data = {24'h0, tblhi_r};
            `REG_PAGE: rd_data = {30'h0, page_r};
            `REG_PADDR: rd_data = {22'h0, paddr_r};
            `REG_PDATA: rd_data = `WORD_ZERO;
            `REG_STATUS: rd_data = {30'h0, seq_r != alu_pkg::st_idle, skip_r};
            default: rd_err = 1'b1;
        endcase
    end
endmodule

// ### core/alu_pkg.sv
// Types shared by the ALU block files
package alu_pkg;
    typedef enum logic [4:0] {
        op_nop = 5'b00000,
        op_rotate_left_thru_flag = 5'b00001,
        op_rotate_left_thru_flag_to_wreg = 5'b00010,
        op_rotate_right_plain = 5'b00011,
        op_rotate_right_to_wreg = 5'b00100,
        op_rotate_right_thru_flag = 5'b00101,
        op_rotate_right_thru_flag_to_wreg = 5'b00110,
        op_subtract_with_borrow = 5'b00111,
        op_subtract_with_borrow_to_mem = 5'b01000,
        op_subtract_plain = 5'b01001,
        op_subtract_plain_to_mem = 5'b01010,
        op_subtract_immediate = 5'b01011,
        op_decrement_skip_if_zero = 5'b01100,
        op_decrement_skip_to_wreg = 5'b01101,
        op_increment_skip_if_zero = 5'b01110,
        op_increment_skip_to_wreg = 5'b01111,
        op_set_byte = 5'b10000,
        op_set_bit = 5'b10001,
        op_skip_if_bit_one = 5'b10010,
        op_skip_if_bit_zero = 5'b10011,
        op_skip_if_null = 5'b10100,
        op_copy_and_skip_if_null = 5'b10101,
        op_nibble_exchange = 5'b10110,
        op_nibble_exchange_to_wreg = 5'b10111,
        op_table_read_current_page = 5'b11000,
        op_table_read_final_page = 5'b11001,
        op_exclusive_or = 5'b11010,
        op_exclusive_or_to_mem = 5'b11011,
        op_exclusive_or_immediate = 5'b11100
    } op_e;
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_exec = 2'b01,
        st_dummy = 2'b10
    } seq_e;
endpackage

// ### core/axil_slave.sv
// AXI4-Lite slave front end that hands single accesses to register logic
`include "alu_cfg.svh"
module axil_slave (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Write address and data
    input wire logic [`ADDR_W-1:0] s_awaddr,
    input wire logic s_awvalid,
    output logic s_awready,
    input wire logic [31:0] s_wdata,
    input wire logic [3:0] s_wstrb,
    input wire logic s_wvalid,
    output logic s_wready,
    // Write response
    output logic [1:0] s_bresp,
    output logic s_bvalid,
    input wire logic s_bready,
    // Read address and data
    input wire logic [`ADDR_W-1:0] s_araddr,
    input wire logic s_arvalid,
    output logic s_arready,
    output logic [31:0] s_rdata,
    output logic [1:0] s_rresp,
    output logic s_rvalid,
    input wire logic s_rready,
    // Register side
    output logic wr_req,
    output logic [`ADDR_W-1:0] wr_addr,
    output logic [31:0] wr_data,
    output logic [3:0] wr_strb,
    input wire logic wr_ack,
    input wire logic wr_err,
    output logic [`ADDR_W-1:0] rd_addr,
    input wire logic [31:0] rd_data,
    input wire logic rd_err
);
    logic aw_have_r, w_have_r, wr_busy_r, ar_have_r;

    assign s_awready = ~aw_have_r;
    assign s_wready = ~w_have_r;
    assign s_arready = ~ar_have_r;
    assign wr_req = aw_have_r & w_have_r & ~wr_busy_r;

    // Write capture in either order, response after the ack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_have_r <= 1'b0;
            w_have_r <= 1'b0;
            wr_busy_r <= 1'b0;
            s_bvalid <= 1'b0;
            s_bresp <= `RESP_OKAY;
            wr_addr <= '0;
            wr_data <= `WORD_ZERO;
            wr_strb <= 4'h0;
        end else begin
            if (s_awvalid && !aw_have_r) begin
                aw_have_r <= 1'b1;
                wr_addr <= s_awaddr;
            end
            if (s_wvalid && !w_have_r) begin
                w_have_r <= 1'b1;
                wr_data <= s_wdata;
                wr_strb <= s_wstrb;
            end
            if (wr_req) begin
                wr_busy_r <= 1'b1;
            end
            if (wr_ack) begin
                s_bvalid <= 1'b1;
                s_bresp <= wr_err ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_bvalid && s_bready) begin
                s_bvalid <= 1'b0;
                aw_have_r <= 1'b0;
                w_have_r <= 1'b0;
                wr_busy_r <= 1'b0;
            end
        end
    end

    // Read capture, data sampled one cycle later
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ar_have_r <= 1'b0;
            rd_addr <= '0;
            s_rvalid <= 1'b0;
            s_rdata <= `WORD_ZERO;
            s_rresp <= `RESP_OKAY;
        end else begin
            if (s_arvalid && !ar_have_r) begin
                ar_have_r <= 1'b1;
                rd_addr <= s_araddr;
            end
            if (ar_have_r && !s_rvalid) begin
                s_rvalid <= 1'b1;
                s_rdata <= rd_data;
                s_rresp <= rd_err ? `RESP_SLVERR : `RESP_OKAY;
            end else if (s_rvalid && s_rready) begin
                s_rvalid <= 1'b0;
                ar_have_r <= 1'b0;
            end
        end
    end
endmodule

// ### core/prog_mem.sv
// Program word store with one write port and a registered read port
`include "alu_cfg.svh"
module prog_mem (
    // Clock
    input wire logic aclk,
    // Write port
    input wire logic we,
    input wire logic [`PROG_AW-1:0] waddr,
    input wire logic [`PROG_DW-1:0] wdata,
    // Read port, data one cycle after address
    input wire logic [`PROG_AW-1:0] raddr,
    output logic [`PROG_DW-1:0] rdata
);
    logic [`PROG_DW-1:0] words [0:(1<<`PROG_AW)-1];

    // Store and fetch; contents have no reset
    always_ff @(posedge aclk) begin
        if (we) begin
            words[waddr] <= wdata;
        end
        rdata <= words[raddr];
    end
endmodule

// ### verif/alu_exec_checker.sv
// Handshake checker on the ALU block's register bus
module alu_exec_checker (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus signals watched
    input wire logic s_awready,
    input wire logic s_bvalid,
    input wire logic s_bready,
    input wire logic [1:0] s_bresp,
    input wire logic s_arvalid,
    input wire logic s_arready,
    input wire logic s_rvalid,
    input wire logic s_rready,
    input wire logic [31:0] s_rdata
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    property p_bhold; s_bvalid && !s_bready |=> s_bvalid; endproperty
    a_bhold: assert property (p_bhold) else $error("bvalid dropped");
    property p_rhold; s_rvalid && !s_rready |=>
        s_rvalid && $stable(s_rdata); endproperty
    a_rhold: assert property (p_rhold) else $error("rvalid dropped");
    property p_awblk; s_bvalid |-> !s_awready; endproperty
    a_awblk: assert property (p_awblk) else $error("write taken early");
    property p_arblk; s_rvalid |-> !s_arready; endproperty
    a_arblk: assert property (p_arblk) else $error("read taken early");
    property p_rlat; s_arvalid && s_arready |-> ##[1:2] s_rvalid; endproperty
    a_rlat: assert property (p_rlat) else $error("read answer late");
    property p_bone; s_bvalid && s_bready |=> !s_bvalid; endproperty
    a_bone: assert property (p_bone) else $error("extra write answer");
    property p_bcode; s_bvalid |-> !s_bresp[0]; endproperty
    a_bcode: assert property (p_bcode) else $error("bad write code");
    property p_rst; disable iff (1'h0) !aresetn |=> !s_bvalid; endproperty
    a_rst: assert property (p_rst) else $error("answer after reset");
endmodule
bind alu_exec alu_exec_checker u_chk (.*);

// ### verif/alu_exec_tb.sv
// Bench driving each ALU operation through the register bus
module alu_exec_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 1'h0, aresetn = 1'h0, slow = 1'h0, s_bready, s_rready;
    logic s_awvalid = 1'h0, s_wvalid = 1'h0, s_arvalid = 1'h0, s_awready;
    logic s_wready, s_bvalid, s_arready, s_rvalid;
    logic [7:0] s_awaddr = 8'h00, s_araddr = 8'h00;
    logic [31:0] s_wdata = 32'h0, s_rdata;
    logic [3:0] s_wstrb = 4'hF;
    logic [1:0] s_bresp, s_rresp;
    logic [33:0] q[$];
    int mismatches = 0, cmp_count = 0, cyc = 0;
    always #25 aclk = ~aclk;
    alu_exec uut (.*);
    axi_resp_sink partner (.*);
    task automatic cmp(input logic [33:0] s, e);
        cmp_count++;
        if (s !== e) begin
            mismatches++;
            $display("[ERR] %0t got %h want %h", $time, s, e);
        end
    endtask
    task automatic test_done;
        if (mismatches == 0 && cmp_count > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d,
                      input logic [1:0] e);
        s_awaddr <= a;
        s_wdata <= d;
        s_awvalid <= 1'h1;
        s_wvalid <= 1'h1;
        do begin
            @(posedge aclk);
            if (s_awready) s_awvalid <= 1'h0;
            if (s_wready) s_wvalid <= 1'h0;
        end while (!(s_bvalid && s_bready));
        cmp(34'(s_bresp), 34'(e));
    endtask
    task automatic rd(input logic [7:0] a, input logic [33:0] e);
        q.push_back(e);
        s_araddr <= a;
        s_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_arready);
        s_arvalid <= 1'h0;
        do @(posedge aclk); while (!(s_rvalid && s_rready));
    endtask
    // One command on random operands, memory byte 0, 1, FF or random
    task automatic run(input logic [6:0] j);
        logic [7:0] w, x, m, r, b, n;
        logic [8:0] d;
        logic [4:0] h, op;
        logic [3:0] f, g;
        logic [2:0] i;
        logic z, k;
        op = j[6:2];
        w = 8'($urandom);
        x = 8'($urandom);
        f = 4'($urandom);
        i = 3'($urandom);
        m = j[1:0] == 2'h3 ? 8'($urandom) : j[1] ? 8'hFF : {7'h0, j[0]};
        b = op == 5'h0B ? x : m;
        z = op < 5'h09 && !f[0];
        d = {1'h0, w} - b - z;
        h = {1'h0, w[3:0]} - b[3:0] - z;
        g = f;
        k = 1'h0;
        r = m;
        n = w;
        case (op)
            1, 2: {g[0], r} = {m, f[0]};
            3, 4: r = {m[0], m[7:1]};
            5, 6: {r, g[0]} = {f[0], m};
            7, 8, 9, 10, 11: begin
                r = d[7:0];
                g = {(w[7] ^ b[7]) & (w[7] ^ d[7]), r == 8'h00, h[4], !d[8]};
            end
            12, 13: {k, r} = {m == 8'h01, m - 8'h01};
            14, 15: {k, r} = {m == 8'hFF, m + 8'h01};
            16: r = 8'hFF;
            17: r[i] = 1'h1;
            18: k = m[i];
            19: k = !m[i];
            20, 21: k = m == 8'h00;
            22, 23: r = {m[3:0], m[7:4]};
            24, 25: r = ~m;
            26, 27, 28: begin
                r = w ^ (op[1] ? m : x);
                g[2] = r == 8'h00;
            end
            default: ;
        endcase
        if (op inside {2, 4, 6, 7, 9, 11, 13, 15, 21, 23, 26, 28}) begin
            n = r;
            r = m;
        end
        if (op inside {24, 25}) begin
            wr(8'h18, {30'h0, f[1:0]}, 2'h0);
            wr(8'h1C, {22'h0, op[0] ? 2'h3 : f[1:0], x}, 2'h0);
            wr(8'h20, {18'h0, w[5:0], ~m}, 2'h0);
            wr(8'h10, {24'h0, x}, 2'h0);
        end
        wr(8'h04, {24'h0, w}, 2'h0);
        wr(8'h08, {24'h0, m}, 2'h0);
        wr(8'h0C, {28'h0, f}, 2'h0);
        wr(8'h00, {8'h0, x, 5'h0, i, 3'h0, op}, 2'h0);
        rd(8'h04, {26'h0, n});
        rd(8'h08, {26'h0, r});
        rd(8'h0C, {30'h0, g});
        rd(8'h24, {33'h0, k});
        if (op inside {24, 25}) rd(8'h14, {28'h0, w[5:0]});
    endtask
    // Oldest expectation against each read answer; hang guard
    always @(posedge aclk) begin
        if (s_rvalid && s_rready) cmp({s_rresp, s_rdata}, q.pop_front());
        cyc++;
        if (cyc == 30000) begin
            mismatches++;
            test_done;
        end
    end
    // Reset, unmapped access, all operations
    initial begin
        void'($urandom(32'h5934D190));
        repeat (12) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        rd(8'h0C, 34'h0);
        wr(8'h28, 32'h1, 2'h2);
        rd(8'h28, {2'h2, 32'h0});
        for (int j = 0; j < 128; j++) begin
            slow <= j[0];
            run(7'(j));
        end
        test_done;
    end
endmodule

// ### verif/axi_resp_sink.sv
// Ready model for the response channels, prompt or stalling
module axi_resp_sink (
    input wire logic aclk,
    input wire logic slow,
    input wire logic s_bvalid,
    input wire logic s_rvalid,
    output logic s_bready,
    output logic s_rready
);
    timeunit 1ns;
    timeprecision 1ns;
    // A raised ready stays up until its answer is taken
    always @(posedge aclk) begin
        s_bready <= s_bready && !s_bvalid || !slow || 1'($urandom);
        s_rready <= s_rready && !s_rvalid || !slow || 1'($urandom);
    end
endmodule
